// ---- core/pla_pkg.sv ----
// Shared constants and operation codes for the packed lane arithmetic datapath.
// Assumes a single 200 MHz core clock domain; nothing here holds logic.
package pla_pkg;

  localparam int VEC_W  = 128;
  localparam int SP_EW  = 8;
  localparam int SP_MW  = 23;
  localparam int DP_EW  = 11;
  localparam int DP_MW  = 52;
  localparam int SP_BIAS = 127;
  localparam int DP_BIAS = 1023;

  // Rebias from single to double exponent (1023 - 127)
  localparam logic [10:0]  SP_TO_DP_REBIAS = 11'h380;
  localparam logic [31:0]  INT32_INDEF     = 32'h8000_0000;
  localparam logic [63:0]  INT64_INDEF     = 64'h8000_0000_0000_0000;
  localparam logic [15:0]  SAT16_MAX       = 16'h7fff;
  localparam logic [15:0]  SAT16_MIN       = 16'h8000;

  localparam logic [127:0] RESULT_RST      = 128'h0;
  localparam logic         VALID_RST       = 1'b0;
  localparam logic         UNKNOWN_RST     = 1'b0;

  typedef enum logic [4:0] {
    OP_ALT_SUB_ADD_SINGLE  = 5'h00,
    OP_ALT_SUB_ADD_DOUBLE  = 5'h01,
    OP_HORIZ_SUM_SINGLE    = 5'h02,
    OP_HORIZ_DIFF_SINGLE   = 5'h03,
    OP_HORIZ_SUM_DOUBLE    = 5'h04,
    OP_HORIZ_DIFF_DOUBLE   = 5'h05,
    OP_ODD_LANE_DUPLICATE  = 5'h06,
    OP_EVEN_LANE_DUPLICATE = 5'h07,
    OP_HALF_DUPLICATE_64   = 5'h08,
    OP_PAIR_SUM_WORD       = 5'h09,
    OP_PAIR_SUM_WORD_SAT   = 5'h0a,
    OP_PAIR_SUM_DWORD      = 5'h0b,
    OP_PAIR_DIFF_WORD      = 5'h0c,
    OP_PAIR_DIFF_WORD_SAT  = 5'h0d,
    OP_PAIR_DIFF_DWORD     = 5'h0e,
    OP_MAGNITUDE_BYTE      = 5'h0f,
    OP_MAGNITUDE_WORD      = 5'h10,
    OP_MAGNITUDE_DWORD     = 5'h11,
    OP_FLOAT_TO_INT_TRUNC  = 5'h12,
    OP_INT_TO_FLOAT        = 5'h13,
    OP_STACK_INT_STORE_TRUNC = 5'h14,
    OP_LANE_ADD_64         = 5'h15,
    OP_LANE_SUB_64         = 5'h16
  } pla_op_e;

endpackage

// ---- core/pla_fp_addsub.sv ----
// Combinational binary floating-point add/subtract for one lane.
// Assumes round to nearest even; subnormal inputs and results flush to zero.
`timescale 1ns/1ps
module pla_fp_addsub
  import pla_pkg::*;
#(
  parameter int EW = SP_EW,
  parameter int MW = SP_MW
) (
  input  wire logic [EW+MW:0] op_x,     // Minuend or first addend
  input  wire logic [EW+MW:0] op_y,     // Subtrahend or second addend
  input  wire logic           subtract, // High to form op_x - op_y
  output logic      [EW+MW:0] sum       // Rounded result
);

  localparam int W = EW + MW + 1;
  localparam int X = MW + 4;
  localparam logic [EW-1:0] EMAX = '1;

  logic [EW-1:0]        ex;
  logic [EW-1:0]        ey;
  logic [EW-1:0]        el;
  logic [EW-1:0]        es;
  logic [EW-1:0]        ed;
  logic                 sx;
  logic                 sy;
  logic                 sl;
  logic                 ss;
  logic                 swap;
  logic                 nan_x;
  logic                 nan_y;
  logic                 inf_x;
  logic                 inf_y;
  logic [X-1:0]         mx;
  logic [X-1:0]         my;
  logic [X-1:0]         ml;
  logic [X-1:0]         ms;
  logic [X-1:0]         msh;
  logic [X-1:0]         nrm;
  logic [X:0]           acc;
  logic signed [EW+1:0] e;
  logic [MW+1:0]        rnd;
  logic                 rup;
  int                   lz;

  assign ex    = op_x[W-2:MW];
  assign ey    = op_y[W-2:MW];
  assign sx    = op_x[W-1];
  assign sy    = op_y[W-1] ^ subtract;
  assign nan_x = (ex == EMAX) && (op_x[MW-1:0] != '0);
  assign nan_y = (ey == EMAX) && (op_y[MW-1:0] != '0);
  assign inf_x = (ex == EMAX) && (op_x[MW-1:0] == '0);
  assign inf_y = (ey == EMAX) && (op_y[MW-1:0] == '0);
  assign mx    = (ex == '0) ? '0 : {1'b1, op_x[MW-1:0], 3'b000};
  assign my    = (ey == '0) ? '0 : {1'b1, op_y[MW-1:0], 3'b000};
  assign swap  = {ey, op_y[MW-1:0]} > {ex, op_x[MW-1:0]};
  assign el    = swap ? ey : ex;
  assign es    = swap ? ex : ey;
  assign ml    = swap ? my : mx;
  assign ms    = swap ? mx : my;
  assign sl    = swap ? sy : sx;
  assign ss    = swap ? sx : sy;
  assign ed    = el - es;

  always_comb begin
    lz  = 0;
    nrm = '0;
    // Align the smaller operand, folding lost bits into a sticky bit
    if (ed >= EW'(X)) begin
      msh = {{(X-1){1'b0}}, |ms};
    end else begin
      msh = (ms >> ed) | X'(|(ms & ~({X{1'b1}} << ed)));
    end
    acc = (sl == ss) ? ({1'b0, ml} + {1'b0, msh}) : ({1'b0, ml} - {1'b0, msh});
    e   = (EW+2)'(el);
    if (acc[X]) begin
      nrm = {acc[X:2], |acc[1:0]};
      e   = e + (EW+2)'(1);
    end else begin
      for (int i = 0; i < X; i++) begin
        if (acc[i]) begin
          lz = X - 1 - i;
        end
      end
      nrm = acc[X-1:0] << lz;
      e   = e - (EW+2)'(lz);
    end
    rup = nrm[2] & (nrm[3] | nrm[1] | nrm[0]);
    rnd = {1'b0, nrm[X-1:3]} + (MW+2)'(rup);
    e   = e + (EW+2)'(rnd[MW+1]);
    if (nan_x || nan_y || (inf_x && inf_y && (sx != sy))) begin
      sum = {1'b0, EMAX, 1'b1, {(MW-1){1'b0}}};
    end else if (inf_x) begin
      sum = {sx, EMAX, {MW{1'b0}}};
    end else if (inf_y) begin
      sum = {sy, EMAX, {MW{1'b0}}};
    end else if (acc == '0) begin
      sum = {sl & ss, {(W-1){1'b0}}};
    end else if (e <= 0) begin
      sum = {sl, {(W-1){1'b0}}};
    end else if (e >= (EW+2)'(EMAX)) begin
      sum = {sl, EMAX, {MW{1'b0}}};
    end else begin
      sum = {sl, e[EW-1:0], rnd[MW-1:0]};
    end
  end

endmodule

// ---- core/pla_datapath.sv ----
// Packed lane arithmetic and lane rearrangement datapath on 128-bit operands.
// Assumes decode and the vector register file drive op_valid, op_sel and both
// operands from the same clock; the result appears one edge after op_valid.
// What this block does
// - Single alternating: subtract even lanes, add odd
// - Double alternating: subtract low lane, add high
// - Single horizontal add of adjacent pairs, both operands
// - Single horizontal subtract: even minus following odd
// - Double horizontal add: each operand's two lanes
// - Double horizontal subtract: low minus high lane
// - Copy odd 32-bit lanes down one lane
// - Copy even 32-bit lanes up one lane
// - Duplicate low 64 bits into both halves
// - Wrapping word pair sums, destination in low half
// - Saturating word pair sums clamp to 16 bits
// - Doubleword pair sums from both operands
// - Word pair differences: lower word minus higher
// - Saturating word pair differences clamp to 16 bits
// - Doubleword pair differences: lower minus upper
// - Magnitude per byte, word or doubleword lane
// - Float to int32 always truncates toward zero
// - Int32 lanes convert to single in place
// - Stack integer store truncates, ignoring rounding mode
// - Independent 64-bit lane add and subtract
`timescale 1ns/1ps
module pla_datapath
  import pla_pkg::*;
(
  input  wire logic             clock,        // Core clock, 200 MHz
  input  wire logic             resetn,       // Asynchronous reset, active low
  input  wire logic             op_valid,     // Operation request this cycle
  input  wire pla_op_e          op_sel,       // Operation select
  input  wire logic [VEC_W-1:0] operand_a,    // First / destination operand
  input  wire logic [VEC_W-1:0] operand_b,    // Second / source operand or memory data
  output logic      [VEC_W-1:0] result,       // Packed result
  output logic                  result_valid, // Result updated this cycle
  output logic                  op_unknown    // Last request had an unmapped select
);

  // Exact widening of a single value to double; subnormals flush to zero
  function automatic logic [63:0] sp_to_dp(input logic [31:0] f);
    logic [10:0] ed;
    if (f[30:23] == 8'hff) begin
      ed = 11'h7ff;
    end else if (f[30:23] == 8'h00) begin
      ed = 11'h000;
    end else begin
      ed = {3'b000, f[30:23]} + SP_TO_DP_REBIAS;
    end
    return {f[31], ed, (ed == 11'h000) ? 23'h0 : f[22:0], 29'h0};
  endfunction

  // Double to signed 64-bit integer, always toward zero
  function automatic logic [63:0] dp_to_int64(input logic [63:0] d);
    logic [10:0] e;
    logic [63:0] m;
    logic [63:0] mag;
    int          sh;
    e  = d[62:52];
    m  = {11'h000, 1'b1, d[51:0]};
    sh = int'(e) - DP_BIAS - DP_MW;
    if (e < 11'(DP_BIAS)) begin
      mag = 64'h0;
    end else if (int'(e) - DP_BIAS >= 63) begin
      return INT64_INDEF;
    end else if (sh >= 0) begin
      mag = m << sh;
    end else begin
      mag = m >> (-sh);
    end
    return d[63] ? 64'(-mag) : mag;
  endfunction

  // Single to int32 by truncation; out of range gives the indefinite value
  function automatic logic [31:0] sp_to_int32(input logic [31:0] f);
    logic [63:0] v;
    v = dp_to_int64(sp_to_dp(f));
    if ((v[63:31] == '0) || (v[63:31] == '1)) begin
      return v[31:0];
    end
    return INT32_INDEF;
  endfunction

  // Int32 to single, round to nearest even
  function automatic logic [31:0] int_to_sp(input logic [31:0] v);
    logic [31:0] mag;
    logic [31:0] nrm;
    logic [24:0] rnd;
    logic [7:0]  ex;
    logic        rup;
    int          lz;
    lz  = 0;
    mag = v[31] ? 32'(-v) : v;
    for (int i = 0; i < 32; i++) begin
      if (mag[i]) begin
        lz = 31 - i;
      end
    end
    nrm = mag << lz;
    rup = nrm[7] & (nrm[8] | (|nrm[6:0]));
    rnd = {1'b0, nrm[31:8]} + 25'(rup);
    ex  = 8'(SP_BIAS + 31 - lz) + 8'(rnd[24]);
    if (mag == 32'h0) begin
      return 32'h0;
    end
    return {v[31], ex, rnd[22:0]};
  endfunction

  logic [VEC_W-1:0] sp_arith;
  logic [VEC_W-1:0] dp_arith;
  logic [VEC_W-1:0] word_sum;
  logic [VEC_W-1:0] word_sum_sat;
  logic [VEC_W-1:0] word_diff;
  logic [VEC_W-1:0] word_diff_sat;
  logic [VEC_W-1:0] dword_sum;
  logic [VEC_W-1:0] dword_diff;
  logic [VEC_W-1:0] mag_byte;
  logic [VEC_W-1:0] mag_word;
  logic [VEC_W-1:0] mag_dword;
  logic [VEC_W-1:0] cvt_f2i;
  logic [VEC_W-1:0] cvt_i2f;
  logic [VEC_W-1:0] quad_sum;
  logic [VEC_W-1:0] quad_diff;
  logic [VEC_W-1:0] odd_dup;
  logic [VEC_W-1:0] even_dup;
  logic [VEC_W-1:0] half_dup;
  logic [VEC_W-1:0] stack_trunc;
  logic [VEC_W-1:0] next_result;
  logic             next_unknown;
  logic             sp_horiz;
  logic             sp_hdiff;
  logic             sp_alt;
  logic             dp_horiz;
  logic             dp_hdiff;
  logic             dp_alt;

  assign sp_alt   = (op_sel == OP_ALT_SUB_ADD_SINGLE);
  assign sp_hdiff = (op_sel == OP_HORIZ_DIFF_SINGLE);
  assign sp_horiz = (op_sel == OP_HORIZ_SUM_SINGLE) || sp_hdiff;
  assign dp_alt   = (op_sel == OP_ALT_SUB_ADD_DOUBLE);
  assign dp_hdiff = (op_sel == OP_HORIZ_DIFF_DOUBLE);
  assign dp_horiz = (op_sel == OP_HORIZ_SUM_DOUBLE) || dp_hdiff;

  // Four single-precision lanes: vertical for alternating, paired for horizontal
  for (genvar i = 0; i < 4; i++) begin : g_sp
    logic [VEC_W-1:0] hsrc;
    logic [31:0]      x;
    logic [31:0]      y;
    assign hsrc = (i < 2) ? operand_a : operand_b;
    assign x    = sp_horiz ? hsrc[64*(i%2) +: 32] : operand_a[32*i +: 32];
    assign y    = sp_horiz ? hsrc[64*(i%2)+32 +: 32] : operand_b[32*i +: 32];
    pla_fp_addsub #(.EW(SP_EW), .MW(SP_MW)) u_add (
      .op_x     (x),
      .op_y     (y),
      .subtract (sp_hdiff || (sp_alt && (i % 2 == 0))),
      .sum      (sp_arith[32*i +: 32])
    );
  end

  // Two double-precision lanes
  for (genvar j = 0; j < 2; j++) begin : g_dp
    logic [VEC_W-1:0] hsrc;
    logic [63:0]      x;
    logic [63:0]      y;
    assign hsrc = (j == 0) ? operand_a : operand_b;
    assign x    = dp_horiz ? hsrc[63:0] : operand_a[64*j +: 64];
    assign y    = dp_horiz ? hsrc[127:64] : operand_b[64*j +: 64];
    pla_fp_addsub #(.EW(DP_EW), .MW(DP_MW)) u_add (
      .op_x     (x),
      .op_y     (y),
      .subtract (dp_hdiff || (dp_alt && (j == 0))),
      .sum      (dp_arith[64*j +: 64])
    );
  end

  // Word pair lanes: 0..3 from the destination operand, 4..7 from the source
  for (genvar k = 0; k < 8; k++) begin : g_word_pair
    logic [VEC_W-1:0]   src;
    logic signed [16:0] s;
    logic signed [16:0] d;
    assign src = (k < 4) ? operand_a : operand_b;
    assign s   = 17'(signed'(src[32*(k%4) +: 16])) + 17'(signed'(src[32*(k%4)+16 +: 16]));
    assign d   = 17'(signed'(src[32*(k%4) +: 16])) - 17'(signed'(src[32*(k%4)+16 +: 16]));
    assign word_sum[16*k +: 16]  = s[15:0];
    assign word_diff[16*k +: 16] = d[15:0];
    assign word_sum_sat[16*k +: 16] = (s > 17'sh0_7fff) ? SAT16_MAX :
                                      (s < -17'sh0_8000) ? SAT16_MIN : s[15:0];
    assign word_diff_sat[16*k +: 16] = (d > 17'sh0_7fff) ? SAT16_MAX :
                                       (d < -17'sh0_8000) ? SAT16_MIN : d[15:0];
  end

  // Doubleword pairs, conversions and lane duplication on 32-bit lanes
  for (genvar k = 0; k < 4; k++) begin : g_dword
    logic [VEC_W-1:0] src;
    assign src = (k < 2) ? operand_a : operand_b;
    assign dword_sum[32*k +: 32]  = src[64*(k%2) +: 32] + src[64*(k%2)+32 +: 32];
    assign dword_diff[32*k +: 32] = src[64*(k%2) +: 32] - src[64*(k%2)+32 +: 32];
    assign cvt_f2i[32*k +: 32]    = sp_to_int32(operand_b[32*k +: 32]);
    assign cvt_i2f[32*k +: 32]    = int_to_sp(operand_b[32*k +: 32]);
    assign odd_dup[32*k +: 32]    = operand_b[32*(k|1) +: 32];
    assign even_dup[32*k +: 32]   = operand_b[32*(k&2) +: 32];
  end

  // Magnitudes; the most negative value wraps to its own unsigned magnitude
  for (genvar k = 0; k < 16; k++) begin : g_mag
    logic [7:0] b;
    assign b = operand_b[8*k +: 8];
    assign mag_byte[8*k +: 8] = b[7] ? 8'(-b) : b;
    if (k < 8) begin : g_w
      logic [15:0] w;
      assign w = operand_b[16*k +: 16];
      assign mag_word[16*k +: 16] = w[15] ? 16'(-w) : w;
    end
    if (k < 4) begin : g_d
      logic [31:0] dw;
      assign dw = operand_b[32*k +: 32];
      assign mag_dword[32*k +: 32] = dw[31] ? 32'(-dw) : dw;
    end
  end

  // Quadword lanes, each with its own carry chain
  for (genvar j = 0; j < 2; j++) begin : g_quad
    assign quad_sum[64*j +: 64]  = operand_a[64*j +: 64] + operand_b[64*j +: 64];
    assign quad_diff[64*j +: 64] = operand_a[64*j +: 64] - operand_b[64*j +: 64];
  end

  // Register or memory source arrives in the low half of operand_b
  assign half_dup    = {operand_b[63:0], operand_b[63:0]};
  // Rounding mode is not an input, so the store can only truncate
  assign stack_trunc = {64'h0, dp_to_int64(operand_b[63:0])};

  always_comb begin
    next_unknown = 1'b0;
    case (op_sel)
      OP_ALT_SUB_ADD_SINGLE,
      OP_HORIZ_SUM_SINGLE,
      OP_HORIZ_DIFF_SINGLE:     next_result = sp_arith;
      OP_ALT_SUB_ADD_DOUBLE,
      OP_HORIZ_SUM_DOUBLE,
      OP_HORIZ_DIFF_DOUBLE:     next_result = dp_arith;
      OP_ODD_LANE_DUPLICATE:    next_result = odd_dup;
      OP_EVEN_LANE_DUPLICATE:   next_result = even_dup;
      OP_HALF_DUPLICATE_64:     next_result = half_dup;
      OP_PAIR_SUM_WORD:         next_result = word_sum;
      OP_PAIR_SUM_WORD_SAT:     next_result = word_sum_sat;
      OP_PAIR_SUM_DWORD:        next_result = dword_sum;
      OP_PAIR_DIFF_WORD:        next_result = word_diff;
      OP_PAIR_DIFF_WORD_SAT:    next_result = word_diff_sat;
      OP_PAIR_DIFF_DWORD:       next_result = dword_diff;
      OP_MAGNITUDE_BYTE:        next_result = mag_byte;
      OP_MAGNITUDE_WORD:        next_result = mag_word;
      OP_MAGNITUDE_DWORD:       next_result = mag_dword;
      OP_FLOAT_TO_INT_TRUNC:    next_result = cvt_f2i;
      OP_INT_TO_FLOAT:          next_result = cvt_i2f;
      OP_STACK_INT_STORE_TRUNC: next_result = stack_trunc;
      OP_LANE_ADD_64:           next_result = quad_sum;
      OP_LANE_SUB_64:           next_result = quad_diff;
      default: begin
        next_result  = RESULT_RST;
        next_unknown = 1'b1;
      end
    endcase
  end

  // Result holds between requests so downstream may sample late
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      result       <= RESULT_RST;
      result_valid <= VALID_RST;
      op_unknown   <= UNKNOWN_RST;
    end else begin
      result_valid <= op_valid;
      if (op_valid) begin
        result     <= next_result;
        op_unknown <= next_unknown;
      end
    end
  end

endmodule

// ---- tb/pla_datapath_sva.sv ----
// Port checker for the packed lane datapath: latency, hold and lane maps.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/1ps
module pla_datapath_chk
  import pla_pkg::*;
(
  input wire logic             clock,        // Core clock
  input wire logic             resetn,       // Reset, active low
  input wire logic             op_valid,     // Request strobe
  input wire pla_op_e          op_sel,       // Operation select
  input wire logic [VEC_W-1:0] operand_a,    // First operand
  input wire logic [VEC_W-1:0] operand_b,    // Second operand
  input wire logic [VEC_W-1:0] result,       // Packed result
  input wire logic             result_valid, // Result strobe
  input wire logic             op_unknown    // Unmapped select flag
);
  wire [3:0][31:0] la = operand_a;
  wire [3:0][31:0] lb = operand_b;
  wire [1:0][63:0] qa = operand_a;
  wire [1:0][63:0] qb = operand_b;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_take(pla_op_e op);
    op_valid && op_sel == op;
  endsequence

  // Mapped operation lands one edge later with the flag clear
  property p_map(pla_op_e op, logic [VEC_W-1:0] want);
    s_take(op) |=> result == want && !op_unknown;
  endproperty

  a_valid_follows: assert property (op_valid |=> result_valid)
    else $error("result strobe missing after request");
  a_idle_holds: assert property (!op_valid |=> !result_valid && $stable(result))
    else $error("result moved without request");
  a_lane_add: assert property (p_map(OP_LANE_ADD_64, {$past(qa[1]+qb[1]), $past(qa[0]+qb[0])}))
    else $error("lane add wrong");
  a_lane_sub: assert property (p_map(OP_LANE_SUB_64, {$past(qa[1]-qb[1]), $past(qa[0]-qb[0])}))
    else $error("lane subtract wrong");
  a_odd_dup: assert property (p_map(OP_ODD_LANE_DUPLICATE, {{2{$past(lb[3])}}, {2{$past(lb[1])}}}))
    else $error("odd duplicate wrong");
  a_even_dup: assert property (p_map(OP_EVEN_LANE_DUPLICATE, {{2{$past(lb[2])}}, {2{$past(lb[0])}}}))
    else $error("even duplicate wrong");
  a_half_dup: assert property (p_map(OP_HALF_DUPLICATE_64, {2{$past(qb[0])}}))
    else $error("half duplicate wrong");
  a_dword_sum: assert property (p_map(OP_PAIR_SUM_DWORD,
    {$past(lb[3]+lb[2]), $past(lb[1]+lb[0]), $past(la[3]+la[2]), $past(la[1]+la[0])}))
    else $error("dword pair sum wrong");
  a_dword_diff: assert property (p_map(OP_PAIR_DIFF_DWORD,
    {$past(lb[2]-lb[3]), $past(lb[0]-lb[1]), $past(la[2]-la[3]), $past(la[0]-la[1])}))
    else $error("dword pair difference wrong");
  a_unknown_zero: assert property (op_valid && op_sel > OP_LANE_SUB_64 |=> op_unknown && result == '0)
    else $error("unmapped select not flagged");
endmodule

bind pla_datapath pla_datapath_chk chk_u (
  .clock(clock), .resetn(resetn), .op_valid(op_valid), .op_sel(op_sel),
  .operand_a(operand_a), .operand_b(operand_b), .result(result),
  .result_valid(result_valid), .op_unknown(op_unknown));

// ---- tb/pla_decode_model.sv ----
// Decode and register file stand-in: issues queued requests back to back.
// Assumes the bench queues requests through issue and shares the core clock.
`timescale 1ns/1ps
module pla_decode_model
  import pla_pkg::*;
(
  input  wire logic             clock,     // Core clock
  output logic                  op_valid,  // Request strobe
  output pla_op_e               op_sel,    // Operation select
  output logic      [VEC_W-1:0] operand_a, // First operand
  output logic      [VEC_W-1:0] operand_b  // Second operand
);
  typedef struct packed {
    pla_op_e          op;
    logic [VEC_W-1:0] a;
    logic [VEC_W-1:0] b;
  } pla_req_s;
  pla_req_s req_q[$];
  pla_req_s cur;

  task automatic issue(input pla_op_e op, input logic [VEC_W-1:0] a, input logic [VEC_W-1:0] b);
    req_q.push_back('{op, a, b});
  endtask

  initial begin
    op_valid  = 1'b0;
    op_sel    = OP_ALT_SUB_ADD_SINGLE;
    operand_a = '0;
    operand_b = '0;
  end

  // Idle operands flip every cycle so stale data never passes for valid
  always @(posedge clock) begin
    #1;
    if (req_q.size() > 0) begin
      cur       = req_q.pop_front();
      op_valid  = 1'b1;
      op_sel    = cur.op;
      operand_a = cur.a;
      operand_b = cur.b;
    end else begin
      op_valid  = 1'b0;
      operand_a = ~operand_a;
      operand_b = ~operand_b;
    end
  end
endmodule

// ---- tb/pla_datapath_test.sv ----
// Self-checking bench for the packed lane datapath fed by the decode model.
// Assumes one 200 MHz clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module pla_datapath_test
  import pla_pkg::*;
;
  localparam logic [127:0] FA = {32'h4080_0000, 32'h4040_0000, 32'h4000_0000, 32'h3f80_0000};
  localparam logic [127:0] FB = {4{32'h3f80_0000}};
  localparam logic [127:0] DA = {64'h4000_0000_0000_0000, 64'h3ff0_0000_0000_0000};
  localparam logic [127:0] DB = {64'h4010_0000_0000_0000, 64'h3ff0_0000_0000_0000};
  logic             clock;
  logic             resetn;
  logic             op_valid;
  pla_op_e          op_sel;
  logic [VEC_W-1:0] operand_a;
  logic [VEC_W-1:0] operand_b;
  logic [VEC_W-1:0] result;
  logic             result_valid;
  logic             op_unknown;
  logic [VEC_W:0]   got_q[$];
  logic [VEC_W:0]   exp_q[$];
  int               err_count;
  int               tests_run;

  pla_decode_model model_u (.clock(clock), .op_valid(op_valid), .op_sel(op_sel),
    .operand_a(operand_a), .operand_b(operand_b));
  pla_datapath dut_u (.clock(clock), .resetn(resetn), .op_valid(op_valid), .op_sel(op_sel),
    .operand_a(operand_a), .operand_b(operand_b), .result(result),
    .result_valid(result_valid), .op_unknown(op_unknown));

  initial clock = 1'b0;
  always #2.5 clock = ~clock;

  always @(posedge clock) begin
    if (result_valid === 1'b1) got_q.push_back({op_unknown, result});
  end

  task automatic check_res(input logic [VEC_W:0] got, input logic [VEC_W:0] want);
    tests_run++;
    if (got !== want) begin
      err_count++;
      $display("unexpected at %0t: result %h want %h", $time, got, want);
    end
  endtask

  task automatic check_bit(input logic got, input logic want);
    tests_run++;
    if (got !== want) begin
      err_count++;
      $display("unexpected at %0t: flag %b want %b", $time, got, want);
    end
  endtask

  task automatic run(input pla_op_e op, input logic [127:0] a, b, e, input logic u = 1'b0);
    model_u.issue(op, a, b);
    exp_q.push_back({u, e});
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (got_q.size() < exp_q.size() && n < 100) begin
      @(posedge clock);
      n++;
    end
    check_bit(got_q.size() == exp_q.size(), 1'b1);
    while (exp_q.size() > 0 && got_q.size() > 0) check_res(got_q.pop_front(), exp_q.pop_front());
    exp_q.delete();
    got_q.delete();
  endtask

  task automatic t_reset();
    check_res({op_unknown, result}, '0);
    check_bit(result_valid, 1'b0);
  endtask

  task automatic t_float();
    run(OP_ALT_SUB_ADD_SINGLE, FA, FB, {32'h40a0_0000, 32'h4000_0000, 32'h4040_0000, 32'h0});
    run(OP_HORIZ_SUM_SINGLE, FA, FB, {32'h4000_0000, 32'h4000_0000, 32'h40e0_0000, 32'h4040_0000});
    run(OP_HORIZ_DIFF_SINGLE, FA, FB, {32'h0, 32'h0, 32'hbf80_0000, 32'hbf80_0000});
    run(OP_ALT_SUB_ADD_DOUBLE, DA, DB, {64'h4018_0000_0000_0000, 64'h0});
    run(OP_HORIZ_SUM_DOUBLE, DA, DB, {64'h4014_0000_0000_0000, 64'h4008_0000_0000_0000});
    run(OP_HORIZ_DIFF_DOUBLE, DA, DB, {64'hc008_0000_0000_0000, 64'hbff0_0000_0000_0000});
    drain();
  endtask

  task automatic t_dup();
    run(OP_ODD_LANE_DUPLICATE, FB, FA, {{2{32'h4080_0000}}, {2{32'h4000_0000}}});
    run(OP_EVEN_LANE_DUPLICATE, FB, FA, {{2{32'h4040_0000}}, {2{32'h3f80_0000}}});
    run(OP_HALF_DUPLICATE_64, FB, FA, {2{64'h4000_0000_3f80_0000}});
    drain();
  endtask

  task automatic t_words();
    logic [127:0] da;
    logic [127:0] db;
    da = {4{16'hfffe, 16'h7fff}};
    db = {4{16'h0002, 16'h8000}};
    run(OP_PAIR_SUM_WORD, {8{16'h7fff}}, {8{16'h8000}}, {{4{16'h0}}, {4{16'hfffe}}});
    run(OP_PAIR_SUM_WORD_SAT, {8{16'h7fff}}, {8{16'h8000}}, {{4{16'h8000}}, {4{16'h7fff}}});
    run(OP_PAIR_SUM_WORD_SAT, {8{16'h0001}}, {8{16'hffff}}, {{4{16'hfffe}}, {4{16'h0002}}});
    run(OP_PAIR_DIFF_WORD, da, db, {{4{16'h7ffe}}, {4{16'h8001}}});
    run(OP_PAIR_DIFF_WORD_SAT, da, db, {{4{16'h8000}}, {4{16'h7fff}}});
    drain();
  endtask

  task automatic t_dwords();
    logic [127:0] b;
    b = {32'h4, 32'h3, 32'h2, 32'h1};
    run(OP_PAIR_SUM_DWORD, {4{32'h8000_0001}}, b, {32'h7, 32'h3, 32'h2, 32'h2});
    run(OP_PAIR_DIFF_DWORD, {32'h1, 32'h5, 32'h0, 32'h7}, b,
      {32'hffff_ffff, 32'hffff_ffff, 32'h4, 32'h7});
    drain();
  endtask

  task automatic t_int();
    logic [127:0] qa;
    qa = {64'h1, 64'hffff_ffff_ffff_ffff};
    run(OP_MAGNITUDE_BYTE, FA, {4{32'hff80_fffe}}, {4{32'h0180_0102}});
    run(OP_MAGNITUDE_WORD, FA, {4{32'hff80_fffe}}, {4{32'h0080_0002}});
    run(OP_MAGNITUDE_DWORD, FA, {4{32'hff80_fffe}}, {4{32'h007f_0002}});
    run(OP_FLOAT_TO_INT_TRUNC, FA, {32'h4020_0000, 32'hc020_0000, 32'h3fe0_0000, 32'hbf40_0000},
      {32'h2, 32'hffff_fffe, 32'h1, 32'h0});
    run(OP_INT_TO_FLOAT, FA, {32'h3, 32'hffff_ffff, 32'h0, 32'h2},
      {32'h4040_0000, 32'hbf80_0000, 32'h0, 32'h4000_0000});
    run(OP_STACK_INT_STORE_TRUNC, FA, {64'h0, 64'hc006_0000_0000_0000},
      {64'h0, 64'hffff_ffff_ffff_fffe});
    run(OP_LANE_ADD_64, qa, {64'h2, 64'h1}, {64'h3, 64'h0});
    run(OP_LANE_SUB_64, qa, {64'h2, 64'h1},
      {64'hffff_ffff_ffff_ffff, 64'hffff_ffff_ffff_fffe});
    drain();
  endtask

  task automatic t_unknown();
    run(pla_op_e'(5'h1f), FA, FB, '0, 1'b1);
    drain();
    repeat (3) @(posedge clock);
    #1;
    check_res({op_unknown, result}, {1'b1, 128'h0});
    check_bit(result_valid, 1'b0);
    run(OP_HALF_DUPLICATE_64, FA, DB, {2{64'h3ff0_0000_0000_0000}});
    drain();
  endtask

  task automatic results();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    err_count = 0;
    tests_run = 0;
    resetn = 1'b0;
    repeat (4) @(posedge clock);
    #1;
    t_reset();
    resetn = 1'b1;
    // Queue the first request only after the model has seen an edge out of reset
    @(posedge clock);
    t_float();
    t_dup();
    t_words();
    t_dwords();
    t_int();
    t_unknown();
    results();
  end

  initial begin
    #5000;
    err_count++;
    results();
  end
endmodule
